/* bench/mbc_matrix_sva.sv */
`default_nettype none
module mbc_matrix_sva (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // watched inputs
    input wire logic primary_input_pair,
    input wire logic secondary_input_pair,
    input wire logic input_pair_choice,
    input wire logic loop_return_clock,
    input wire logic [3:0] bank_off,
    input wire logic loop_bank_off,
    // watched outputs
    input wire logic [15:0] bank_lanes,
    input wire logic [1:0] loop_bank_outputs,
    input wire logic lock
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    logic ref_sel;
    assign ref_sel = input_pair_choice ? secondary_input_pair
        : primary_input_pair;
    sequence ref_only_s;
        $rose(ref_sel) && !$rose(loop_return_clock);
    endsequence
    sequence both_rise_s;
        $rose(ref_sel) && $rose(loop_return_clock);
    endsequence
    reset_clear_a: assert property ($fell(reset) |->
        bank_lanes == 16'h0000 && loop_bank_outputs == 2'h0 && !lock)
        else $error("lanes not cleared by reset");
    first_off_a: assert property (bank_off[0] |=>
        bank_lanes[3:0] == 4'h0) else $error("bank one not off");
    last_off_a: assert property (bank_off[3] |=>
        bank_lanes[15:12] == 4'h0) else $error("bank four not off");
    loop_off_a: assert property (loop_bank_off |=>
        loop_bank_outputs == 2'h0) else $error("loop bank not off");
    lanes_match_a: assert property (
        bank_lanes[3:0] inside {4'h0, 4'hF}
        && bank_lanes[7:4] inside {4'h0, 4'hF}
        && bank_lanes[11:8] inside {4'h0, 4'hF}
        && bank_lanes[15:12] inside {4'h0, 4'hF})
        else $error("bank lanes differ");
    loop_match_a: assert property (
        loop_bank_outputs[0] == loop_bank_outputs[1])
        else $error("loop lanes differ");
    lock_set_a: assert property (both_rise_s |-> ##[1:3] lock)
        else $error("no lock on aligned edges");
    lock_drop_a: assert property (ref_only_s |-> ##[1:3] !lock)
        else $error("lock kept on stray edge");
    // hold steps only stretch a lane; eight steps is the shortest period
    lane_period_a: assert property ($rose(bank_lanes[0]) |=>
        (!$rose(bank_lanes[0])) [*7]) else $error("lane period too short");
endmodule
bind mbc_matrix mbc_matrix_sva u_sva (.clock(clock), .reset(reset),
    .primary_input_pair(primary_input_pair),
    .secondary_input_pair(secondary_input_pair),
    .input_pair_choice(input_pair_choice),
    .loop_return_clock(loop_return_clock), .bank_off(bank_off),
    .loop_bank_off(loop_bank_off), .bank_lanes(bank_lanes),
    .loop_bank_outputs(loop_bank_outputs), .lock(lock));
`default_nettype wire

/* bench/mbc_ref_model.sv */
`default_nettype none
// board reference source; both pairs stand still while run is low
module mbc_ref_model #(
    parameter int PERIOD = 16
) (
    // clock and control
    input wire logic clock,
    input wire logic reset,
    input wire logic run,
    // reference pairs
    output logic primary_input_pair,
    output logic secondary_input_pair
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] cnt;
        logic a;
        logic b;
    } mbc_ref_t;
    mbc_ref_t st_r;
    mbc_ref_t st_nxt;
    always_comb
    begin
        st_nxt.cnt = (st_r.cnt == 8'(PERIOD - 1)) ? 8'h00 : st_r.cnt + 8'h01;
        st_nxt.a = run && st_r.cnt < 8'(PERIOD / 2);
        // half a period off, so a switch forces reacquisition
        st_nxt.b = run && st_r.cnt >= 8'(PERIOD / 2);
    end
    always_ff @(posedge clock)
    begin
        st_r <= reset ? '0 : st_nxt;
    end
    assign primary_input_pair = st_r.a;
    assign secondary_input_pair = st_r.b;
endmodule
`default_nettype wire

/* bench/tb_multi_bank_clock_divide_phase_select.sv */
`default_nettype none
module tb_multi_bank_clock_divide_phase_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic run = 1'b0;
    logic ch = 1'b0;
    logic [1:0] rs = 2'h2;
    logic [15:0] ps = 16'h5555;
    logic [15:0] ds = 16'h0000;
    logic [3:0] off = 4'h0;
    logic [1:0] lps = 2'h1;
    logic [3:0] lds = 4'h0;
    logic loff = 1'b0;
    logic pa;
    logic pb;
    logic [15:0] lanes;
    logic [1:0] ll;
    logic lock;
    int failures = 0;
    int comparisons = 0;
    always #5 clock = ~clock;
    mbc_matrix DUT (.clock(clock), .reset(reset), .primary_input_pair(pa),
        .secondary_input_pair(pb), .input_pair_choice(ch),
        .loop_return_clock(ll[0]), .freq_range_select(rs),
        .bank_phase_select(ps), .bank_divide_select(ds), .bank_off(off),
        .loop_bank_phase_select(lps), .loop_bank_divide_select(lds),
        .loop_bank_off(loff), .bank_lanes(lanes), .loop_bank_outputs(ll),
        .lock(lock));
    mbc_ref_model u_ref (.clock(clock), .reset(reset), .run(run),
        .primary_input_pair(pa), .secondary_input_pair(pb));
    function automatic logic [3:0] code(input int c);
        return 4'((c / 3) * 4 + c % 3);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic restart();
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
    endtask
    // 0..15 bank lanes, 16 and 17 loop lanes, 18 the chosen reference
    function automatic logic lane_bit(input int i);
        if (i < 16)
            return lanes[i];
        else if (i < 18)
            return ll[i - 16];
        else
            return ch ? pb : pa;
    endfunction
    // n + 1 is the distance to the next rise of lane i
    task automatic rise(input int i, output int n);
        logic p;
        p = lane_bit(i);
        n = 0;
        @(negedge clock);
        while (!(lane_bit(i) && !p) && n < 1000)
        begin
            p = lane_bit(i);
            n++;
            @(negedge clock);
        end
    endtask
    // a positive skew delays a lane: it rises s steps after bank two
    task automatic lag(input int i, input int s, input int p);
        int n;
        rise(4, n);
        rise(i, n);
        check(16'((n + 1) % p), 16'((p + s) % p));
    endtask
    task automatic divide_test();
        int dv[9] = '{1, 2, 3, 4, 5, 6, 8, 10, 12};
        int n;
        for (int c = 0; c < 9; c++)
        begin
            @(posedge clock);
            ds <= {4{code(c)}};
            lds <= code(c);
            restart();
            for (int i = 0; i <= 16; i += 4)
            begin
                rise(i, n);
                rise(i, n);
                check(16'(n + 1), 16'(dv[c] * 16));
            end
        end
    endtask
    task automatic skew_test();
        int b12[9] = '{-4, -3, -2, -1, 0, 1, 2, 3, 4};
        // ML and MH copy banks one and two, set here to -1 and 0
        int b34[9] = '{-8, -7, -6, -1, 0, 0, 6, 7, 8};
        int lp[4] = '{-4, 0, 4, 0};
        for (int c = 0; c < 9; c++)
        begin
            @(posedge clock);
            ds <= 16'h0000;
            lds <= 4'h0;
            ps <= {4'h5, code(c), 4'h5, code(c)};
            lps <= 2'(c % 4);
            restart();
            lag(0, b12[c], 16);
            lag(8, b34[c], 16);
            lag(16, lp[c % 4], 16);
        end
    endtask
    task automatic wait_lock(input logic v, input int lim);
        for (int k = 0; k < lim && lock !== v; k++)
            @(negedge clock);
        check({15'h0, lock}, {15'h0, v});
    endtask
    task automatic lock_test();
        int n;
        @(posedge clock);
        ps <= 16'h5555;
        lps <= 2'h1;
        run <= 1'b1;
        restart();
        wait_lock(1'b1, 100);
        @(posedge clock);
        ch <= 1'b1;
        wait_lock(1'b0, 40);
        wait_lock(1'b1, 400);
        rise(18, n);
        rise(16, n);
        check(16'((n + 1) % 16), 16'h0000);
        // loop skew +4 leaves a zero-skew bank four steps ahead of reference
        @(posedge clock);
        lps <= 2'h2;
        wait_lock(1'b0, 40);
        wait_lock(1'b1, 400);
        rise(18, n);
        rise(4, n);
        check(16'((n + 1) % 16), 16'h000C);
        @(posedge clock);
        run <= 1'b0;
    endtask
    task automatic range_test();
        int nf[4] = '{64, 32, 16, 32};
        int n;
        for (int r = 0; r < 4; r++)
        begin
            @(posedge clock);
            rs <= 2'(r);
            restart();
            rise(0, n);
            rise(0, n);
            check(16'(n + 1), 16'(nf[r]));
        end
        @(posedge clock);
        off <= 4'hF;
        loff <= 1'b1;
        repeat (3) @(negedge clock);
        check(lanes, 16'h0000);
        check({14'h0, ll}, 16'h0000);
    endtask
    initial
    begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        divide_test();
        skew_test();
        lock_test();
        range_test();
        finish_test();
    end
    // the full run needs about 10000 cycles
    initial
    begin
        #400000;
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire

/* core/mbc_bank.sv */
`default_nettype none
// one divided, skewed clock lane; every bank counts on the same step enable
module mbc_bank #(
    parameter int PW = 10
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // step control
    input wire logic adv,
    input wire logic [PW-1:0] period,
    input wire logic [4:0] skew,
    input wire logic off,
    // lane
    output logic lane
);
    // the sign-extended skew needs at least five bits
    if (PW < 5)
    begin : g_bad_width
        $error("period width too small");
    end

    typedef struct packed {
        logic [PW-1:0] cnt;
        logic lane;
    } mbc_bank_t;

    mbc_bank_t st_r;
    mbc_bank_t st_nxt;
    logic [PW+1:0] pos;
    logic [PW+1:0] per_x;

    always_comb
    begin
        st_nxt = st_r;
        per_x = {2'h0, period};
        // a positive skew delays the lane; period is at least 8, so one
        // added period keeps the position non-negative
        pos = {2'h0, st_r.cnt} + per_x - {{(PW-3){skew[4]}}, skew};
        if (pos >= per_x)
            pos = pos - per_x;
        if (pos >= per_x)
            pos = pos - per_x;
        if (adv)
        begin
            if (st_r.cnt >= period - 1'b1)
                st_nxt.cnt = '0;
            else
                st_nxt.cnt = st_r.cnt + 1'b1;
        end
        // base rate when divide is one
        st_nxt.lane = ~off && (pos < {3'h0, period[PW-1:1]});
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign lane = st_r.lane;
endmodule
`default_nettype wire

/* core/mbc_matrix.sv */
// Operation
// - four output banks, four lanes, two phase and two divide selects, off
// - loop-return bank: two lanes, two divide selects, one phase select, off
// - divide selects decode to 1,2,3,4,5,6,8,10,12 for every bank
// - banks one and two skew -4..+4 steps from two phase selects
// - banks three, four skew -8,-7,-6,0,6,7,8; ML/MH follow banks 1/2
// - loop bank skew -4, 0, +4 for LOW, MID, HIGH
// - skew step is base period divided by factor N
// - N is 64/32/16 slow variant, 32/16/8 fast variant
// - divide-by-one lanes run at the base output frequency
// - loop aligns returned clock rising edge to reference rising edge
// - nonzero loop-return skew shifts all other outputs by its negative
// - on reference switch no output period gets shorter than nominal
// - detector compares reference and returned clock, steers step timing by holding a step
// - three-level pins read LOW, MID or HIGH; open reads MID
// - input pair choice LOW picks primary, HIGH picks secondary
`default_nettype none
module mbc_matrix #(
    parameter bit FAST_VARIANT = 1'b0
) (
    // clock and reset; one clock cycle is one skew step
    input wire logic clock,
    input wire logic reset,
    // reference inputs, sampled levels
    input wire logic primary_input_pair,
    input wire logic secondary_input_pair,
    input wire logic input_pair_choice,
    input wire logic loop_return_clock,
    // strap selects, two bits per three-level pin
    input wire logic [1:0] freq_range_select,
    input wire logic [15:0] bank_phase_select,
    input wire logic [15:0] bank_divide_select,
    input wire logic [3:0] bank_off,
    input wire logic [1:0] loop_bank_phase_select,
    input wire logic [3:0] loop_bank_divide_select,
    input wire logic loop_bank_off,
    // clock lanes and status
    output logic [15:0] bank_lanes,
    output logic [1:0] loop_bank_outputs,
    output logic lock
);
    localparam int PW = mbc_pkg::PERIOD_W;

    // the longest period, 12 * 64 steps, needs ten bits
    if (PW < 10)
    begin : g_bad_width
        $error("period width too small for the longest divide");
    end

    // ========================================
    // three-level decode
    // two bits per pin: 0 low, 1 mid, 2 high, 3 open
    // open pin reads as mid
    function automatic logic [1:0] lvl(input logic [1:0] code);
        lvl = (code == mbc_pkg::LVL_OPEN) ? mbc_pkg::LVL_MID : code;
    endfunction

    function automatic logic [3:0] idx9(input logic [1:0] hi,
                                        input logic [1:0] lo);
        logic [3:0] h;
        h = {2'h0, lvl(hi)};
        idx9 = (h << 1) + h + {2'h0, lvl(lo)};
    endfunction

    // ========================================
    // step factor
    logic [1:0] fr;
    logic [6:0] n_fac;
    always_comb
    begin
        fr = lvl(freq_range_select);
        if (FAST_VARIANT)
            n_fac = mbc_pkg::N_FAST[fr];
        else
            n_fac = mbc_pkg::N_SLOW[fr];
    end

    // ========================================
    // per-bank decode
    logic [4:0] skew [5];
    logic [PW-1:0] period [5];
    logic [3:0] pidx [4];
    logic [3:0] didx [5];
    logic [4:0] raw_skew [4];
    logic [4:0] lane_out;

    always_comb
    begin
        for (int b = 0; b < 4; b++)
        begin
            pidx[b] = idx9(bank_phase_select[4*b+3 -: 2],
                           bank_phase_select[4*b+1 -: 2]);
            didx[b] = idx9(bank_divide_select[4*b+3 -: 2],
                           bank_divide_select[4*b+1 -: 2]);
            raw_skew[b] = mbc_pkg::SKEW_B12[pidx[b]];
        end
        didx[4] = idx9(loop_bank_divide_select[3:2],
                       loop_bank_divide_select[1:0]);
        skew[0] = raw_skew[0];
        skew[1] = raw_skew[1];
        for (int b = 2; b < 4; b++)
        begin
            if (pidx[b] == 4'(mbc_pkg::IDX_FOLLOW_FIRST))
                skew[b] = raw_skew[0];
            else if (pidx[b] == 4'(mbc_pkg::IDX_FOLLOW_SECOND))
                skew[b] = raw_skew[1];
            else
                skew[b] = mbc_pkg::SKEW_B34[pidx[b]];
        end
        // loop bank, only three codes exist, open is mid
        skew[4] = mbc_pkg::SKEW_LOOP[lvl(loop_bank_phase_select)];
        for (int b = 0; b < 5; b++)
        begin
            // ratio, period = ratio * N steps
            // both factors are widened first so 12 * 64 is not cut short
            period[b] = PW'(mbc_pkg::DIV_TABLE[didx[b]]) * PW'(n_fac);
        end
    end

    // ========================================
    // phase detector state
    typedef struct packed {
        logic ref_d;
        logic ret_d;
        logic stall;
        mbc_pkg::mbc_det_t det;
    } mbc_top_t;

    mbc_top_t st_r;
    mbc_top_t st_nxt;
    logic ref_now;
    logic ref_rise;
    logic ret_rise;

    always_comb
    begin
        st_nxt = st_r;
        // both pairs share one edge detector, so a switch reads as a stray edge
        // reference pair choice
        ref_now = input_pair_choice ? secondary_input_pair
                                    : primary_input_pair;
        ref_rise = ref_now & ~st_r.ref_d;
        ret_rise = loop_return_clock & ~st_r.ret_d;
        st_nxt.ref_d = ref_now;
        st_nxt.ret_d = loop_return_clock;
        st_nxt.stall = 1'b0;
        // compare edges and steer step timing
        if (ref_rise)
        begin
            case (st_r.det)
                mbc_pkg::DET_SEEK,
                mbc_pkg::DET_LOCK:
                begin
                    // align returned edge; skew shift follows
                    // only ever hold a step, never skip one
                    // a hold only stretches a lane period, so a reference
                    // switch can never shorten one below nominal
                    if (ret_rise)
                        st_nxt.det = mbc_pkg::DET_LOCK;
                    else
                    begin
                        st_nxt.det = mbc_pkg::DET_SEEK;
                        st_nxt.stall = 1'b1;
                    end
                end
                default:
                    st_nxt.det = mbc_pkg::DET_SEEK;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            st_r.ref_d <= 1'b0;
            st_r.ret_d <= 1'b0;
            st_r.stall <= 1'b0;
            st_r.det <= mbc_pkg::DET_SEEK;
        end
        else
            st_r <= st_nxt;
    end

    // ========================================
    // banks: four output banks, loop-return bank
    // ratio and skew changes take effect at once; a counter above a new,
    // shorter period wraps on its next step
    logic [4:0] off_v;
    assign off_v = {loop_bank_off, bank_off};

    genvar g;
    generate
        for (g = 0; g < 5; g++)
        begin : g_bank
            mbc_bank #(
                .PW(PW)
            ) u_bank (
                .clock(clock),
                .reset(reset),
                .adv(~st_r.stall),
                .period(period[g]),
                .skew(skew[g]),
                .off(off_v[g]),
                .lane(lane_out[g])
            );
        end
        for (g = 0; g < 4; g++)
        begin : g_lanes
            assign bank_lanes[4*g+3 -: 4] = {4{lane_out[g]}};
        end
    endgenerate

    assign loop_bank_outputs = {2{lane_out[4]}};
    // lock drops on the first reference edge without a returned edge
    assign lock = (st_r.det == mbc_pkg::DET_LOCK);
endmodule
`default_nettype wire

/* core/mbc_pkg.sv */
`default_nettype none
package mbc_pkg;
    // ========================================
    // three-level select codes (two bits per pin)
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_OPEN = 2'h3;

    // ========================================
    // sizes
    localparam int NUM_BANKS = 4;
    localparam int LANES_PER_BANK = 4;
    localparam int PERIOD_W = 10;
    localparam int SKEW_W = 5;

    // ========================================
    // skew-step factor per range select, index LOW, MID, HIGH
    localparam logic [6:0] N_SLOW [3] = '{7'h40, 7'h20, 7'h10};
    localparam logic [6:0] N_FAST [3] = '{7'h20, 7'h10, 7'h08};

    // ========================================
    // divide ratio, index = high digit * 3 + low digit
    localparam logic [3:0] DIV_TABLE [9] =
        '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'hC};

    // ========================================
    // skew in steps, two's complement, same index
    localparam logic [4:0] SKEW_B12 [9] =
        '{5'h1C, 5'h1D, 5'h1E, 5'h1F, 5'h00, 5'h01, 5'h02, 5'h03, 5'h04};
    localparam logic [4:0] SKEW_B34 [9] =
        '{5'h18, 5'h19, 5'h1A, 5'h00, 5'h00, 5'h00, 5'h06, 5'h07, 5'h08};
    localparam int IDX_FOLLOW_FIRST = 3;
    localparam int IDX_FOLLOW_SECOND = 5;
    localparam logic [4:0] SKEW_LOOP [3] = '{5'h1C, 5'h00, 5'h04};

    // ========================================
    // phase detector states
    typedef enum logic [1:0] {
        DET_SEEK = 2'h1,
        DET_LOCK = 2'h2
    } mbc_det_t;
endpackage
`default_nettype wire
